// ---- cesl_pkg.sv ----
// Purpose: Shared constants and types for the controller error status logic.
// Assumes: 32-bit APB register bus, one clock at 10 MHz.
// Notes: Register offsets are byte addresses of aligned words.

package cesl_pkg;

  // ***************************************************************
  // Clock and timing
  // ***************************************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  // Half period of the display flashing, in milliseconds.
  localparam int unsigned FLASH_HALF_MS = 500;
  localparam int unsigned FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_SCALE_HI = 12'h004;
  localparam logic [11:0] OFS_SCALE_LO = 12'h008;
  localparam logic [11:0] OFS_ERRPT_HI = 12'h00c;
  localparam logic [11:0] OFS_ERRPT_LO = 12'h010;
  localparam logic [11:0] OFS_DISP_HI = 12'h014;
  localparam logic [11:0] OFS_DISP_LO = 12'h018;
  localparam logic [11:0] OFS_ACTION = 12'h01c;
  localparam logic [11:0] OFS_STATUS = 12'h020;
  localparam logic [11:0] OFS_ERRCODE = 12'h024;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h028;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h02c;

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int unsigned CTRL_FLASH_BIT = 0;
  localparam int unsigned ACT_EVT_LSB = 16;
  localparam int unsigned ST_INERR = 0;
  localparam int unsigned ST_OVER = 1;
  localparam int unsigned ST_UNDER = 2;
  localparam int unsigned ST_DIAG = 3;
  localparam int unsigned ST_FATAL = 4;
  localparam int unsigned NUM_IRQ = 5;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] DISP_HI_RST = 32'h0000_4e1f;
  localparam logic [31:0] DISP_LO_RST = 32'hffff_b1e1;
  localparam logic [31:0] SCALE_HI_RST = 32'h0000_0190;
  localparam logic [31:0] SCALE_LO_RST = 32'h0000_0000;
  localparam logic [31:0] ACTION_RST = 32'h0000_0000;
  localparam logic [NUM_IRQ-1:0] IRQ_MASK_RST = 5'h00;

  // ***************************************************************
  // Self-diagnostic sources and their code weights
  // ***************************************************************
  localparam int unsigned NUM_DIAG = 7;
  localparam logic [15:0] DIAG_W [NUM_DIAG] = '{
    16'h0001, 16'h0002, 16'h0004, 16'h0020, 16'h009e, 16'h0100, 16'h0800};

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cesl_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cesl_apb_rsp_s;

  typedef enum logic [2:0] {
    PV_SHOW_VALUE,
    PV_SHOW_OVER,
    PV_SHOW_UNDER,
    PV_SHOW_ERR,
    PV_SHOW_BLANK
  } cesl_pv_disp_e;

endpackage

// ---- cesl_top.sv ----
// Purpose: Input error classification, self-diagnostic error code and
//   fatal halt handling for a process controller, with APB registers.
// Assumes: All inputs synchronous to mclk_i; fault inputs active high.
// Notes: Diagnostic and fatal states hold until reset (power cycle).
//
// The APB slave port and the register addresses are this design's own decisions.

`timescale 1ns/100ps
`default_nettype none

module cesl_top
  import cesl_pkg::*;
#(
  parameter int unsigned VW = 20,
  parameter int unsigned NOUT = 2,
  parameter int unsigned NEVT = 4,
  parameter int unsigned FLASH_CYC = FLASH_HALF_CYC
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Register bus
  input wire cesl_apb_req_s apb_i,
  output var cesl_apb_rsp_s apb_o,
  // Measurement path and normal outputs
  input wire logic signed [VW-1:0] measured_value_i,
  input wire logic [NOUT-1:0] ctrl_out_i,
  input wire logic [NEVT-1:0] event_i,
  // Self-check sources, bit order as code weights
  input wire logic [NUM_DIAG-1:0] diag_fault_i,
  input wire logic supply_fault_i,
  input wire logic ram_fault_i,
  // Display, outputs and port
  output var cesl_pv_disp_e pv_disp_sel_o,
  output logic signed [VW-1:0] pv_value_o,
  output logic pv_lit_o,
  output logic sv_show_code_o,
  output logic sv_lit_o,
  output logic [15:0] set_value_code_o,
  output logic [NOUT-1:0] ctrl_out_o,
  output logic [NEVT-1:0] event_o,
  output logic comm_reply_en_o,
  output logic halt_o,
  output logic irq_o
);

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [31:0] ctrl_reg;
  logic [31:0] scale_hi_reg;
  logic [31:0] scale_lo_reg;
  logic [31:0] errpt_hi_reg;
  logic [31:0] errpt_lo_reg;
  logic [31:0] disp_hi_reg;
  logic [31:0] disp_lo_reg;
  logic [31:0] action_reg;
  logic [NUM_IRQ-1:0] irq_stat_reg;
  logic [NUM_IRQ-1:0] irq_mask_reg;
  logic [NUM_DIAG-1:0] diag_flags_reg;
  logic [15:0] errcode_reg;
  logic fatal_reg;
  logic inerr_reg;
  logic over_reg;
  logic under_reg;
  logic [31:0] flash_cnt_reg;
  logic flash_phase_reg;
  logic [31:0] rdata_next;
  logic rd_ok;
  logic wr_en;
  logic [NUM_IRQ-1:0] evt_set;
  logic [15:0] code_next;
  logic signed [VW-1:0] pv;
  logic over_next;
  logic under_next;
  logic inerr_next;
  logic diag_any;

  assign pv = measured_value_i;
  assign diag_any = |diag_flags_reg;
  assign wr_en = apb_i.psel & apb_i.penable & apb_i.pwrite & apb_o.pready;

  // ***************************************************************
  // Measured value classification
  // ***************************************************************
  // Limits are held in the low VW bits of each register.
  always_comb
  begin
    over_next = pv > $signed(disp_hi_reg[VW-1:0]);
    under_next = pv < $signed(disp_lo_reg[VW-1:0]);
    inerr_next = over_next | under_next
      | (pv > $signed(scale_hi_reg[VW-1:0]))
      | (pv < $signed(scale_lo_reg[VW-1:0]))
      | (pv > $signed(errpt_hi_reg[VW-1:0]))
      | (pv < $signed(errpt_lo_reg[VW-1:0]));
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      inerr_reg <= 1'b0;
      over_reg <= 1'b0;
      under_reg <= 1'b0;
    end
    else
    begin
      inerr_reg <= inerr_next;
      over_reg <= over_next;
      under_reg <= under_next;
    end
  end

  // ***************************************************************
  // Self-diagnostic and fatal latches
  // ***************************************************************
  // Sum of active codes.
  always_comb
  begin
    code_next = 16'h0000;
    for (int i = 0; i < NUM_DIAG; i++)
    begin
      if (diag_flags_reg[i])
      begin
        code_next = code_next + DIAG_W[i];
      end
    end
  end

  // A fault stays recorded after its source clears, so the code shown is
  // the history since power-up, not only the present condition.
  genvar g;
  generate
    for (g = 0; g < NUM_DIAG; g++)
    begin : g_diag
      always_ff @(posedge mclk_i)
      begin
        if (sys_rst_i)
        begin
          diag_flags_reg[g] <= 1'b0;
        end
        else if (diag_fault_i[g])
        begin
          diag_flags_reg[g] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      errcode_reg <= 16'h0000;
    end
    else
    begin
      errcode_reg <= code_next;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      fatal_reg <= 1'b0;
    end
    else if (supply_fault_i | ram_fault_i)
    begin
      fatal_reg <= 1'b1;
    end
  end

  // ***************************************************************
  // Flash timebase
  // ***************************************************************
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      flash_cnt_reg <= 32'h0000_0000;
      flash_phase_reg <= 1'b1;
    end
    else if (flash_cnt_reg >= 32'(FLASH_CYC - 1))
    begin
      flash_cnt_reg <= 32'h0000_0000;
      flash_phase_reg <= ~flash_phase_reg;
    end
    else
    begin
      flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
    end
  end

  // ***************************************************************
  // Display drive
  // ***************************************************************
  // Fatal wins over diagnostics, which win over input error.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      pv_disp_sel_o <= PV_SHOW_BLANK;
      pv_value_o <= '0;
      pv_lit_o <= 1'b0;
      sv_show_code_o <= 1'b0;
      sv_lit_o <= 1'b0;
      set_value_code_o <= 16'h0000;
    end
    else if (fatal_reg)
    begin
      pv_disp_sel_o <= PV_SHOW_BLANK;
      pv_lit_o <= 1'b0;
      sv_show_code_o <= 1'b0;
      sv_lit_o <= 1'b0;
      set_value_code_o <= 16'h0000;
    end
    else if (diag_any)
    begin
      pv_disp_sel_o <= PV_SHOW_ERR;
      pv_lit_o <= 1'b1;
      sv_show_code_o <= 1'b1;
      sv_lit_o <= 1'b1;
      set_value_code_o <= errcode_reg;
    end
    else
    begin
      pv_value_o <= pv;
      sv_show_code_o <= 1'b0;
      sv_lit_o <= 1'b1;
      set_value_code_o <= 16'h0000;
      if (over_reg)
      begin
        pv_disp_sel_o <= PV_SHOW_OVER;
        pv_lit_o <= flash_phase_reg;
      end
      else if (under_reg)
      begin
        pv_disp_sel_o <= PV_SHOW_UNDER;
        pv_lit_o <= flash_phase_reg;
      end
      else
      begin
        pv_disp_sel_o <= PV_SHOW_VALUE;
        pv_lit_o <= (inerr_reg & ctrl_reg[CTRL_FLASH_BIT])
          ? flash_phase_reg : 1'b1;
      end
    end
  end

  // ***************************************************************
  // Outputs, events and port
  // ***************************************************************
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_out_o <= '0;
      event_o <= '0;
      comm_reply_en_o <= 1'b0;
      halt_o <= 1'b0;
    end
    else
    begin
      comm_reply_en_o <= ~fatal_reg;
      halt_o <= fatal_reg;
      if (fatal_reg | diag_any)
      begin
        ctrl_out_o <= '0;
        event_o <= '0;
      end
      else if (inerr_reg)
      begin
        ctrl_out_o <= action_reg[NOUT-1:0];
        event_o <= action_reg[ACT_EVT_LSB +: NEVT];
      end
      else
      begin
        ctrl_out_o <= ctrl_out_i;
        event_o <= event_i;
      end
    end
  end

  // ***************************************************************
  // Interrupts
  // ***************************************************************
  assign evt_set[ST_INERR] = inerr_next & ~inerr_reg;
  assign evt_set[ST_OVER] = over_next & ~over_reg;
  assign evt_set[ST_UNDER] = under_next & ~under_reg;
  assign evt_set[ST_DIAG] = |(diag_fault_i & ~diag_flags_reg);
  assign evt_set[ST_FATAL] = (supply_fault_i | ram_fault_i) & ~fatal_reg;

  // A new event in the clearing cycle stays set.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      irq_stat_reg <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      if (wr_en && apb_i.paddr == OFS_IRQ_STAT)
      begin
        irq_stat_reg <= (irq_stat_reg & ~apb_i.pwdata[NUM_IRQ-1:0])
          | evt_set;
      end
      else
      begin
        irq_stat_reg <= irq_stat_reg | evt_set;
      end
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ***************************************************************
  // APB slave
  // ***************************************************************
  always_comb
  begin
    rd_ok = 1'b1;
    rdata_next = 32'h0000_0000;
    if (apb_i.paddr == OFS_CTRL)
      rdata_next = ctrl_reg;
    else if (apb_i.paddr == OFS_SCALE_HI)
      rdata_next = scale_hi_reg;
    else if (apb_i.paddr == OFS_SCALE_LO)
      rdata_next = scale_lo_reg;
    else if (apb_i.paddr == OFS_ERRPT_HI)
      rdata_next = errpt_hi_reg;
    else if (apb_i.paddr == OFS_ERRPT_LO)
      rdata_next = errpt_lo_reg;
    else if (apb_i.paddr == OFS_DISP_HI)
      rdata_next = disp_hi_reg;
    else if (apb_i.paddr == OFS_DISP_LO)
      rdata_next = disp_lo_reg;
    else if (apb_i.paddr == OFS_ACTION)
      rdata_next = action_reg;
    else if (apb_i.paddr == OFS_STATUS)
      rdata_next = {27'h0, fatal_reg, diag_any, under_reg, over_reg,
        inerr_reg};
    else if (apb_i.paddr == OFS_ERRCODE)
      rdata_next = {16'h0000, errcode_reg};
    else if (apb_i.paddr == OFS_IRQ_STAT)
      rdata_next = {27'h0, irq_stat_reg};
    else if (apb_i.paddr == OFS_IRQ_MASK)
      rdata_next = {27'h0, irq_mask_reg};
    else
      rd_ok = 1'b0;
  end

  // No wait state: the answer is prepared from the setup cycle.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      apb_o <= '0;
    end
    else
    begin
      apb_o.pready <= apb_i.psel & ~apb_i.penable;
      apb_o.pslverr <= apb_i.psel & ~apb_i.penable & ~rd_ok;
      apb_o.prdata <= (apb_i.psel & ~apb_i.penable & ~apb_i.pwrite)
        ? rdata_next : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_reg <= CTRL_RST;
      scale_hi_reg <= SCALE_HI_RST;
      scale_lo_reg <= SCALE_LO_RST;
      errpt_hi_reg <= DISP_HI_RST;
      errpt_lo_reg <= DISP_LO_RST;
      disp_hi_reg <= DISP_HI_RST;
      disp_lo_reg <= DISP_LO_RST;
      action_reg <= ACTION_RST;
      irq_mask_reg <= IRQ_MASK_RST;
    end
    else if (wr_en)
    begin
      if (apb_i.paddr == OFS_CTRL)
        ctrl_reg <= apb_i.pwdata & CTRL_RST;
      else if (apb_i.paddr == OFS_SCALE_HI)
        scale_hi_reg <= apb_i.pwdata;
      else if (apb_i.paddr == OFS_SCALE_LO)
        scale_lo_reg <= apb_i.pwdata;
      else if (apb_i.paddr == OFS_ERRPT_HI)
        errpt_hi_reg <= apb_i.pwdata;
      else if (apb_i.paddr == OFS_ERRPT_LO)
        errpt_lo_reg <= apb_i.pwdata;
      else if (apb_i.paddr == OFS_DISP_HI)
        disp_hi_reg <= apb_i.pwdata;
      else if (apb_i.paddr == OFS_DISP_LO)
        disp_lo_reg <= apb_i.pwdata;
      else if (apb_i.paddr == OFS_ACTION)
        action_reg <= apb_i.pwdata;
      else if (apb_i.paddr == OFS_IRQ_MASK)
        irq_mask_reg <= apb_i.pwdata[NUM_IRQ-1:0];
    end
  end

endmodule

`default_nettype wire

// ---- cesl_assertions.sv ----
// Purpose: Port-level checks on the controller error status logic.
// Assumes: Display limits keep their reset values of +19999 and -19999.
// Notes: Bound into every cesl_top instance at the foot of this file.

`timescale 1ns/100ps
`default_nettype none

module cesl_assertions
  import cesl_pkg::*;
#(
  parameter int unsigned VW = 20,
  parameter int unsigned NOUT = 2,
  parameter int unsigned NEVT = 4
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Bus and sources
  input wire cesl_apb_req_s apb_i,
  input wire cesl_apb_rsp_s apb_o,
  input wire logic signed [VW-1:0] measured_value_i,
  input wire logic [NUM_DIAG-1:0] diag_fault_i,
  input wire logic supply_fault_i,
  input wire logic ram_fault_i,
  // Observed outputs
  input wire cesl_pv_disp_e pv_disp_sel_o,
  input wire logic pv_lit_o,
  input wire logic sv_show_code_o,
  input wire logic sv_lit_o,
  input wire logic [15:0] set_value_code_o,
  input wire logic [NOUT-1:0] ctrl_out_o,
  input wire logic [NEVT-1:0] event_o,
  input wire logic comm_reply_en_o,
  input wire logic halt_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  // ***************************************************************
  // Sequences
  // ***************************************************************
  sequence s_dark;
    halt_o && !comm_reply_en_o && !pv_lit_o && !sv_lit_o;
  endsequence
  sequence s_off;
    ctrl_out_o == '0 && event_o == '0;
  endsequence
  sequence s_code_run;
    sv_show_code_o && !halt_o ##1 sv_show_code_o && !halt_o;
  endsequence

  // ***************************************************************
  // Properties
  // ***************************************************************
  a_fatal_halt: assert property (
    (supply_fault_i || ram_fault_i) |-> ##2 s_dark ##0 s_off)
    else $error("fatal source did not halt the unit");
  a_halt_blank: assert property (
    halt_o |-> pv_disp_sel_o == PV_SHOW_BLANK && !sv_show_code_o)
    else $error("halted unit still shows something");
  a_halt_held: assert property (
    halt_o |=> halt_o && !comm_reply_en_o)
    else $error("halt was left without reset");
  a_diag_off: assert property (
    (diag_fault_i != '0) |-> ##2 s_off)
    else $error("outputs stayed on after a diagnostic fault");
  a_diag_mark: assert property (
    (diag_fault_i != '0) |-> ##3 (halt_o || (sv_lit_o &&
    pv_disp_sel_o == PV_SHOW_ERR && sv_show_code_o)))
    else $error("diagnostic fault not shown");
  a_code_kept: assert property (
    s_code_run |-> set_value_code_o >= $past(set_value_code_o))
    else $error("error code dropped while latched");
  a_over_show: assert property (
    (int'(measured_value_i) > 19999) |-> ##2 pv_disp_sel_o inside
    {PV_SHOW_OVER, PV_SHOW_ERR, PV_SHOW_BLANK})
    else $error("over-scale mark missing");
  a_under_show: assert property (
    (int'(measured_value_i) < -19999) |-> ##2 pv_disp_sel_o inside
    {PV_SHOW_UNDER, PV_SHOW_ERR, PV_SHOW_BLANK})
    else $error("underscale mark missing");
  a_apb_answer: assert property (
    apb_i.psel && !apb_i.penable |=> apb_o.pready ##1 !apb_o.pready)
    else $error("bus answer not a single cycle after setup");
endmodule

bind cesl_top cesl_assertions #(.VW(VW), .NOUT(NOUT), .NEVT(NEVT))
  u_cesl_assertions (.mclk_i, .sys_rst_i, .apb_i, .apb_o,
  .measured_value_i, .diag_fault_i, .supply_fault_i, .ram_fault_i,
  .pv_disp_sel_o, .pv_lit_o, .sv_show_code_o, .sv_lit_o,
  .set_value_code_o, .ctrl_out_o, .event_o, .comm_reply_en_o, .halt_o);

`default_nettype wire

// ---- cesl_panel_model.sv ----
// Purpose: Front panel and load driver seen from the block's outputs.
// Assumes: Drives are plain levels on mclk_i.
// Notes: Relays and lamps respond one clock after their drive.

`timescale 1ns/100ps
`default_nettype none

module cesl_panel_model
#(
  parameter int unsigned NOUT = 2,
  parameter int unsigned NEVT = 4
)
(
  // Clock
  input wire logic mclk_i,
  // Drives from the block
  input wire logic pv_lit_i,
  input wire logic sv_lit_i,
  input wire logic [NOUT-1:0] ctrl_i,
  input wire logic [NEVT-1:0] event_i,
  // What the panel shows
  output logic dark_o,
  output logic loads_o
);
  // A relay picks up one clock after any of its drives goes high.
  always_ff @(posedge mclk_i)
  begin
    loads_o <= (|ctrl_i) || (|event_i);
    dark_o <= !pv_lit_i && !sv_lit_i;
  end
endmodule

`default_nettype wire

// ---- test_controller_error_status_logic.sv ----
// Purpose: Self-checking bench for the controller error status logic.
// Assumes: Flash half period shortened to 4 clocks.
// Notes: Each scenario task (t_regs to t_fatal) judges its own results.

`timescale 1ns/100ps
`default_nettype none

module test_controller_error_status_logic
  import cesl_pkg::*;
;
  logic mclk_i, sys_rst_i;
  cesl_apb_req_s apb_i;
  cesl_apb_rsp_s apb_o;
  logic signed [19:0] measured_value_i, pv_value_o;
  logic [1:0] ctrl_out_i, ctrl_out_o;
  logic [3:0] event_i, event_o;
  logic [NUM_DIAG-1:0] diag_fault_i;
  logic supply_fault_i, ram_fault_i;
  cesl_pv_disp_e pv_disp_sel_o;
  logic pv_lit_o, sv_show_code_o, sv_lit_o;
  logic [15:0] set_value_code_o;
  logic comm_reply_en_o, halt_o, irq_o, dark, loads, er;
  logic [31:0] rd;
  int n_fail, n_compared;

  cesl_top #(.FLASH_CYC(4)) u_cesl_top (.mclk_i, .sys_rst_i, .apb_i,
    .apb_o, .measured_value_i, .ctrl_out_i, .event_i, .diag_fault_i,
    .supply_fault_i, .ram_fault_i, .pv_disp_sel_o, .pv_value_o,
    .pv_lit_o, .sv_show_code_o, .sv_lit_o, .set_value_code_o,
    .ctrl_out_o, .event_o, .comm_reply_en_o, .halt_o, .irq_o);
  cesl_panel_model u_cesl_panel_model (.mclk_i, .pv_lit_i(pv_lit_o),
    .sv_lit_i(sv_lit_o), .ctrl_i(ctrl_out_o), .event_i(event_o),
    .dark_o(dark), .loads_o(loads));

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic chk(input logic [31:0] g, e, input string m);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic rst;
    cyc(1);
    sys_rst_i <= 1'b1;
    diag_fault_i <= '0;
    supply_fault_i <= 1'b0;
    ram_fault_i <= 1'b0;
    cyc(6);
    sys_rst_i <= 1'b0;
    cyc(3);
  endtask
  // The request stands until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    cyc(1);
    apb_i <= cesl_apb_req_s'{1'b1, 1'b0, w, a, d};
    cyc(1);
    apb_i.penable <= 1'b1;
    cyc(1);
    while (apb_o.pready !== 1'b1 && k < 16)
    begin
      cyc(1);
      k++;
    end
    rd = apb_o.prdata;
    er = apb_o.pslverr;
    chk(k < 16, 1, "bus answer");
    apb_i <= '0;
  endtask
  task automatic tog(output int t);
    logic p;
    t = 0;
    p = pv_lit_o;
    repeat (20)
    begin
      cyc(1);
      if (pv_lit_o !== p) t++;
      p = pv_lit_o;
    end
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_regs;
    logic [11:0] o [6] = '{OFS_CTRL, OFS_SCALE_HI, OFS_SCALE_LO,
      OFS_DISP_HI, OFS_DISP_LO, OFS_ERRPT_LO};
    logic [31:0] v [6] = '{32'h1, 32'h190, 32'h0, 32'h4e1f,
      32'hffffb1e1, 32'hffffb1e1};
    foreach (o[i])
    begin
      apb(0, o[i], 0);
      chk(rd, v[i], "reset value");
    end
    apb(1, OFS_STATUS, 32'hffffffff);
    apb(0, OFS_STATUS, 0);
    chk(rd, 0, "status is read-only");
    apb(0, 12'h030, 0);
    chk(er, 1, "unmapped read error");
    chk(rd, 0, "unmapped read data");
    chk(pv_disp_sel_o, PV_SHOW_VALUE, "normal display");
    chk(pv_value_o, 100, "value shown");
    chk({ctrl_out_o, event_o, loads}, 7'h2b, "outputs pass");
    $display("t_regs done");
  endtask

  task automatic t_range;
    logic signed [19:0] v [4] = '{20'sd350, -20'sd1, 20'sd20000,
      -20'sd20000};
    cesl_pv_disp_e d [4] = '{PV_SHOW_VALUE, PV_SHOW_VALUE,
      PV_SHOW_OVER, PV_SHOW_UNDER};
    logic [2:0] s [4] = '{3'h1, 3'h1, 3'h3, 3'h5};
    apb(1, OFS_ERRPT_HI, 300);
    apb(1, OFS_ACTION, 32'h000a_0002);
    apb(1, OFS_IRQ_MASK, 32'h2);
    foreach (v[i])
    begin
      measured_value_i <= v[i];
      cyc(3);
      chk(pv_disp_sel_o, d[i], "range display");
      chk(ctrl_out_o, 2, "error output action");
      chk(event_o, 4'ha, "error event action");
      apb(0, OFS_STATUS, 0);
      chk(rd[2:0], s[i], "range status");
      if (i == 0) chk(irq_o, 0, "masked event");
    end
    measured_value_i <= 100;
    cyc(3);
    chk(irq_o, 1, "over event raised");
    apb(0, OFS_IRQ_STAT, 0);
    chk(rd[2:0], 3'h7, "events latched");
    apb(1, OFS_IRQ_STAT, 32'h1f);
    cyc(2);
    chk(irq_o, 0, "event cleared");
    chk(ctrl_out_o, 1, "outputs restored");
    $display("t_range done");
  endtask

  task automatic t_flash;
    int t;
    measured_value_i <= 350;
    cyc(3);
    tog(t);
    chk(t >= 4, 1, "flashing value");
    apb(1, OFS_CTRL, 0);
    // Let the new setting reach the lamp before watching it.
    cyc(2);
    tog(t);
    chk({t == 0, pv_lit_o}, 2'h3, "steady value");
    measured_value_i <= 20000;
    cyc(3);
    tog(t);
    chk(t >= 4, 1, "over-scale flashes");
    measured_value_i <= -20000;
    cyc(3);
    tog(t);
    chk(t >= 4, 1, "underscale flashes");
    measured_value_i <= 100;
    $display("t_flash done");
  endtask

  task automatic t_diag;
    logic [15:0] w [7] = '{16'd1, 16'd2, 16'd4, 16'd32, 16'd158,
      16'd256, 16'd2048};
    ctrl_out_i <= 2'h3;
    event_i <= 4'hf;
    foreach (w[i])
    begin
      rst();
      diag_fault_i <= 7'h1 << i;
      cyc(1);
      diag_fault_i <= '0;
      cyc(4);
      chk(set_value_code_o, w[i], "code");
      chk(pv_disp_sel_o, PV_SHOW_ERR, "error mark");
      chk({sv_show_code_o, comm_reply_en_o}, 2'h3, "code shown");
      chk({ctrl_out_o, event_o, loads}, 0, "outputs off");
    end
    rst();
    diag_fault_i <= 7'h50;
    cyc(1);
    diag_fault_i <= 7'h01;
    cyc(1);
    diag_fault_i <= '0;
    cyc(5);
    chk(set_value_code_o, 2207, "summed code");
    apb(0, OFS_ERRCODE, 0);
    chk(rd, 2207, "code register");
    cyc(10);
    chk(set_value_code_o, 2207, "code held");
    $display("t_diag done");
  endtask

  task automatic t_fatal;
    for (int i = 0; i < 2; i++)
    begin
      rst();
      diag_fault_i <= 7'h01;
      cyc(1);
      diag_fault_i <= '0;
      supply_fault_i <= (i == 0);
      ram_fault_i <= (i == 1);
      cyc(1);
      supply_fault_i <= 1'b0;
      ram_fault_i <= 1'b0;
      cyc(4);
      chk({halt_o, comm_reply_en_o}, 2'h2, "halted, no reply");
      chk(pv_disp_sel_o, PV_SHOW_BLANK, "display blank");
      chk({sv_show_code_o, dark}, 2'h1, "no code, dark");
      chk({ctrl_out_o, event_o, loads}, 0, "all off");
      apb(0, OFS_STATUS, 0);
      chk(rd[4], 1, "fatal status");
    end
    $display("t_fatal done");
  endtask

  task automatic end_of_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  initial
  begin
    #(1_000_000);
    $display("[ERR] %0t watchdog timeout", $time);
    n_fail++;
    end_of_test();
  end

  initial
  begin
    n_fail = 0;
    n_compared = 0;
    sys_rst_i = 1'b1;
    apb_i = '0;
    measured_value_i = 100;
    ctrl_out_i = 2'h1;
    event_i = 4'h5;
    diag_fault_i = '0;
    supply_fault_i = 1'b0;
    ram_fault_i = 1'b0;
    cyc(6);
    sys_rst_i <= 1'b0;
    cyc(3);
    t_regs();
    t_range();
    t_flash();
    t_diag();
    t_fatal();
    end_of_test();
  end
endmodule

`default_nettype wire
